// [rtl/ssr_status.sv]
// Stepper channel status report block with AXI4-Lite register slave
// Summary of operation
// - Status registers answer busy and return zero data while the motor moves.
// - During motion only emergency or decelerating stop commands are accepted.
// - Finish bits 2:0 hold the last executed command code.
// - Finish bit 3 marks a stop forced by inner limits.
// - Finish bit 4 marks a stop forced by outer limits.
// - Finish bit 5 is the inverse of motor power sense.
// - No command executes while motor power sense is low.
// - Finish bit 6 marks a motion aborted by a stop command.
// - Completion flag bit 7 sets when any command completes.
// - Second finish status read after setting clears the completion flag.
// - Bits 3 to 6 all zero means full step count was moved.
// - Input byte: ccw inner, cw inner, ccw outer, cw outer, power, base point.
// - Input bits read high unless at the switch; bits 4 and 5 undefined.
// - Input status is live, never latched.
// - Output bits 7 to 3 mirror the five phase drive outputs.
// - Hold output rises 3 ms after standstill when enabled.
// - Output bit 1 gives last direction, one for counter-clockwise.
// - Output bit 0 is unused.
// - Remaining count holds steps left after abort, zero after completion.
// - Remaining count is an unsigned magnitude.
// - Remaining count is 24 bits wide.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module ssr_status
  import ssr_pkg::*;
#(
  parameter int unsigned HOLD_DELAY_CYCLES = HOLD_CYCLES
)
(
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic MOTION_BUSY_IN,
  input wire logic MOTION_DONE_IN,
  input wire ssr_done_t MOTION_DONE_INFO_IN,
  input wire logic CCW_INNER_LIMIT_IN,
  input wire logic CW_INNER_LIMIT_IN,
  input wire logic CCW_OUTER_LIMIT_IN,
  input wire logic CW_OUTER_LIMIT_IN,
  input wire logic MOTOR_POWER_SENSE_IN,
  input wire logic BASE_POINT_INPUT_IN,
  input wire logic [4:0] PHASE_DRIVE_OUTPUTS_IN,
  output logic CMD_VALID_OUT,
  output logic [2:0] CMD_CODE_OUT,
  output logic CMD_DIR_OUT,
  output logic [STEP_W-1:0] STEP_COUNT_VALUE_OUT,
  output logic HOLD_OUTPUT_OUT,
  output logic IRQ_OUT
);

  ssr_state_t s;
  ssr_state_t next_s;
  logic ar_take;
  logic wr_go;
  logic cmd_take;
  logic cmd_ok;
  logic busy;
  logic fin_rd;
  logic status_rd;
  logic [2:0] cmd_code;

  always_comb
  begin
    next_s = s;
    ar_take = S_AXI_ARVALID_IN && s.ar_rdy;
    wr_go = s.aw_full && s.w_full && !s.bvalid;
    // Raw core busy closes the gap before its registered copy rises
    busy = s.moving || s.cmd_valid || MOTION_BUSY_IN;
    cmd_code = s.w_data[2:0];
    cmd_take = wr_go && (s.aw_addr == OFS_COMMAND) && s.w_strb[0];
    cmd_ok = cmd_take && s.in_stat.power
      && (!busy || cmd_code == CODE_EMERGENCY_STOP || cmd_code == CODE_DECEL_STOP);
    status_rd = (S_AXI_ARADDR_IN == OFS_FINISH) || (S_AXI_ARADDR_IN == OFS_INPUT)
      || (S_AXI_ARADDR_IN == OFS_OUTPUT) || (S_AXI_ARADDR_IN == OFS_REMAIN);
    fin_rd = ar_take && !busy && (S_AXI_ARADDR_IN == OFS_FINISH);

    next_s.cmd_valid = 1'b0;
    next_s.moving = MOTION_BUSY_IN;
    // Sampled every cycle that CE_IN is high, no latching
    next_s.in_stat.ccw_inner = CCW_INNER_LIMIT_IN;
    next_s.in_stat.cw_inner = CW_INNER_LIMIT_IN;
    next_s.in_stat.ccw_outer = CCW_OUTER_LIMIT_IN;
    next_s.in_stat.cw_outer = CW_OUTER_LIMIT_IN;
    next_s.in_stat.spare = 2'h0;
    next_s.in_stat.power = MOTOR_POWER_SENSE_IN;
    next_s.in_stat.base_point = BASE_POINT_INPUT_IN;
    next_s.phase = PHASE_DRIVE_OUTPUTS_IN;
    next_s.fin.power_lost = !MOTOR_POWER_SENSE_IN;

    if (S_AXI_AWVALID_IN && s.aw_rdy)
    begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && s.w_rdy)
    begin
      next_s.w_full = 1'b1;
      next_s.w_data = S_AXI_WDATA_IN;
      next_s.w_strb = S_AXI_WSTRB_IN;
    end
    if (s.bvalid && S_AXI_BREADY_IN)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        OFS_CONTROL:
        begin
          if (s.w_strb[0])
          begin
            next_s.hold_en = s.w_data[CTRL_HOLD_EN_BIT];
            next_s.int_en = s.w_data[CTRL_INT_EN_BIT];
          end
        end
        OFS_STEPS:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (s.w_strb[i])
            begin
              next_s.steps[i*8 +: 8] = s.w_data[i*8 +: 8];
            end
          end
        end
        OFS_COMMAND:
        begin
          if (cmd_ok)
          begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_code = cmd_code;
            next_s.cmd_dir = s.w_data[CMD_DIR_BIT];
            next_s.dir = s.w_data[CMD_DIR_BIT];
            next_s.fin.code = cmd_code;
            next_s.refused = 1'b0;
          end
          else if (cmd_take)
          begin
            // Refusal is visible both in the response and in the status word
            next_s.bresp = RESP_SLVERR;
            next_s.refused = 1'b1;
          end
        end
        OFS_FINISH, OFS_INPUT, OFS_OUTPUT, OFS_REMAIN, OFS_STATUS:
        begin
          next_s.bresp = RESP_OKAY;
        end
        default:
        begin
          next_s.bresp = RESP_DECERR;
        end
      endcase
    end
    next_s.aw_rdy = !next_s.aw_full && !next_s.bvalid;
    next_s.w_rdy = !next_s.w_full && !next_s.bvalid;

    if (s.rvalid && S_AXI_RREADY_IN)
    begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      if (busy && status_rd)
      begin
        next_s.rresp = RESP_SLVERR;
      end
      else
      begin
        unique case (S_AXI_ARADDR_IN)
          OFS_FINISH: next_s.rdata = {24'h0, s.fin};
          OFS_INPUT: next_s.rdata = {24'h0, s.in_stat};
          OFS_OUTPUT: next_s.rdata = {24'h0, s.phase, s.hold, s.dir, 1'b0};
          OFS_REMAIN: next_s.rdata = {8'h0, s.remain};
          OFS_CONTROL: next_s.rdata = {30'h0, s.int_en, s.hold_en};
          OFS_COMMAND: next_s.rdata = {28'h0, s.cmd_dir, s.cmd_code};
          OFS_STEPS: next_s.rdata = {8'h0, s.steps};
          OFS_STATUS: next_s.rdata = {30'h0, s.refused, busy};
          default: next_s.rresp = RESP_DECERR;
        endcase
      end
    end
    next_s.ar_rdy = !next_s.rvalid;

    if (fin_rd && s.fin.flag)
    begin
      if (s.rd_cnt)
      begin
        next_s.fin.flag = 1'b0;
      end
      else
      begin
        next_s.rd_cnt = 1'b1;
      end
    end
    // Completion after the read handling so a new event beats a clear
    if (MOTION_DONE_IN)
    begin
      next_s.fin.flag = 1'b1;
      next_s.rd_cnt = 1'b0;
      next_s.fin.inner_stop = MOTION_DONE_INFO_IN.inner_stop;
      next_s.fin.outer_stop = MOTION_DONE_INFO_IN.outer_stop;
      next_s.fin.aborted = MOTION_DONE_INFO_IN.aborted;
      if (MOTION_DONE_INFO_IN.inner_stop || MOTION_DONE_INFO_IN.outer_stop
          || MOTION_DONE_INFO_IN.aborted)
      begin
        next_s.remain = MOTION_DONE_INFO_IN.remaining;
      end
      else
      begin
        next_s.remain = '0;
      end
    end

    // Counter saturates so the hold level stays up for any rest length
    if (busy)
    begin
      next_s.hold_cnt = '0;
    end
    else if (s.hold_cnt < HOLD_CNT_W'(HOLD_DELAY_CYCLES))
    begin
      next_s.hold_cnt = s.hold_cnt + 1'b1;
    end
    next_s.hold = !busy && s.hold_en
      && (s.hold_cnt == HOLD_CNT_W'(HOLD_DELAY_CYCLES));
    next_s.irq = next_s.int_en && next_s.fin.flag;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      s <= ST_RESET;
    end
    else if (CE_IN)
    begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY_OUT = s.aw_rdy;
  assign S_AXI_WREADY_OUT = s.w_rdy;
  assign S_AXI_BRESP_OUT = s.bresp;
  assign S_AXI_BVALID_OUT = s.bvalid;
  assign S_AXI_ARREADY_OUT = s.ar_rdy;
  assign S_AXI_RDATA_OUT = s.rdata;
  assign S_AXI_RRESP_OUT = s.rresp;
  assign S_AXI_RVALID_OUT = s.rvalid;
  assign CMD_VALID_OUT = s.cmd_valid;
  assign CMD_CODE_OUT = s.cmd_code;
  assign CMD_DIR_OUT = s.cmd_dir;
  assign STEP_COUNT_VALUE_OUT = s.steps;
  assign HOLD_OUTPUT_OUT = s.hold;
  assign IRQ_OUT = s.irq;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence busy_status_read_s;
    CE_IN && ar_take && busy && status_rd;
  endsequence

  sequence refused_answer_s;
    S_AXI_RVALID_OUT && (S_AXI_RRESP_OUT == RESP_SLVERR) && (S_AXI_RDATA_OUT == 32'h0);
  endsequence

  sequence issue_s;
    CE_IN && cmd_ok;
  endsequence

  sequence pulse_s;
    CMD_VALID_OUT && (CMD_CODE_OUT == s.fin.code) ##1 !CMD_VALID_OUT || !CE_IN;
  endsequence

  AST_BUSY_READ: assert property (busy_status_read_s |=> refused_answer_s)
    else $error("status read while moving was not refused");

  AST_MOTION_REFUSED: assert property (CE_IN && cmd_take && busy && cmd_code > CODE_DECEL_STOP
      |=> !CMD_VALID_OUT && S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == RESP_SLVERR)
    else $error("motion command accepted during motion");

  AST_CODE_LATCH: assert property (issue_s |=> pulse_s)
    else $error("issued command code not latched in finish status");

  AST_POWER_REFUSE: assert property (CE_IN && cmd_take && !s.in_stat.power
      |=> !CMD_VALID_OUT && s.refused)
    else $error("command executed without motor power");

  // Reset state holds both bits low, so skip the edge that leaves reset
  AST_POWER_BIT: assert property (CE_IN && $past(RST_N_IN)
      |=> s.fin.power_lost == !s.in_stat.power)
    else $error("power lost bit does not follow power sense");

  AST_DONE_CAUSE: assert property (CE_IN && MOTION_DONE_IN
      |=> s.fin.flag && s.fin.inner_stop == $past(MOTION_DONE_INFO_IN.inner_stop)
      && s.fin.outer_stop == $past(MOTION_DONE_INFO_IN.outer_stop)
      && s.fin.aborted == $past(MOTION_DONE_INFO_IN.aborted))
    else $error("completion did not record flag and cause");

  AST_FLAG_FIRST_READ: assert property (CE_IN && fin_rd && s.fin.flag && !s.rd_cnt
      && !MOTION_DONE_IN |=> s.fin.flag && s.rd_cnt)
    else $error("first finish read changed the completion flag");

  AST_FLAG_CLEAR: assert property (CE_IN && fin_rd && s.fin.flag && s.rd_cnt
      && !MOTION_DONE_IN |=> !s.fin.flag)
    else $error("second finish read did not clear the completion flag");

  AST_REMAIN_ZERO: assert property (CE_IN && MOTION_DONE_IN && !MOTION_DONE_INFO_IN.aborted
      && !MOTION_DONE_INFO_IN.inner_stop && !MOTION_DONE_INFO_IN.outer_stop
      |=> s.remain == '0)
    else $error("remaining count not zero after full move");

  AST_HOLD_RISE: assert property ($rose(HOLD_OUTPUT_OUT)
      |-> s.hold_en && !s.moving && s.hold_cnt == HOLD_CNT_W'(HOLD_DELAY_CYCLES))
    else $error("hold output rose before the standstill delay");

  AST_IRQ: assert property (CE_IN |=> IRQ_OUT == (s.int_en && s.fin.flag))
    else $error("interrupt request does not follow completion flag");

endmodule : ssr_status

// [inc/ssr_pkg.sv]
// Constants and types for the stepper status report block
package ssr_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_DELAY_MS = 3;
  localparam int unsigned HOLD_CYCLES = HOLD_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_CNT_W = 16;
  localparam int unsigned STEP_W = 24;
  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] OFS_FINISH = 8'h00;
  localparam logic [7:0] OFS_INPUT = 8'h04;
  localparam logic [7:0] OFS_OUTPUT = 8'h08;
  localparam logic [7:0] OFS_REMAIN = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h14;
  localparam logic [7:0] OFS_STEPS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  localparam int unsigned CTRL_HOLD_EN_BIT = 0;
  localparam int unsigned CTRL_INT_EN_BIT = 1;
  localparam int unsigned CMD_DIR_BIT = 3;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_REFUSED_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [2:0] CODE_EMERGENCY_STOP = 3'h0;
  localparam logic [2:0] CODE_DECEL_STOP = 3'h1;

  typedef struct packed {
    logic flag;
    logic aborted;
    logic power_lost;
    logic outer_stop;
    logic inner_stop;
    logic [2:0] code;
  } ssr_finish_t;

  typedef struct packed {
    logic base_point;
    logic power;
    logic [1:0] spare;
    logic cw_outer;
    logic ccw_outer;
    logic cw_inner;
    logic ccw_inner;
  } ssr_input_t;

  typedef struct packed {
    logic inner_stop;
    logic outer_stop;
    logic aborted;
    logic [STEP_W-1:0] remaining;
  } ssr_done_t;

  typedef struct packed {
    logic aw_rdy;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic moving;
    ssr_input_t in_stat;
    logic [4:0] phase;
    ssr_finish_t fin;
    logic rd_cnt;
    logic [STEP_W-1:0] remain;
    logic hold_en;
    logic int_en;
    logic hold;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic dir;
    logic [STEP_W-1:0] steps;
    logic refused;
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic cmd_dir;
    logic irq;
  } ssr_state_t;

  localparam ssr_state_t ST_RESET = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};
endpackage : ssr_pkg

// [testbench/ssr_motion_model.sv]
// Motion core stand-in driven by the block's command pulses
`timescale 1ns/1ns
module ssr_motion_model
  import ssr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic [STEP_W-1:0] steps_in,
  input wire logic [1:0] stop_in,
  output logic busy_out,
  output logic done_out,
  output ssr_done_t info_out
);
  logic [STEP_W-1:0] left;
  logic cut;
  assign cut = cmd_valid_in || (stop_in != 2'h0);
  always_ff @(posedge clk_in)
  begin
    done_out <= 1'h0;
    // Info only means something beside done, so it churns otherwise
    info_out <= ~info_out;
    if (!rst_n_in)
    begin
      busy_out <= 1'h0;
      info_out <= '0;
    end
    else if (busy_out && (cut || left == STEP_W'(1)))
    begin
      busy_out <= 1'h0;
      done_out <= 1'h1;
      info_out <= {stop_in[0], stop_in[1], cmd_valid_in, cut ? left : {STEP_W{1'h0}}};
    end
    else if (busy_out)
      left <= left - STEP_W'(1);
    else if (cmd_valid_in)
    begin
      busy_out <= cmd_code_in > 3'h1;
      done_out <= cmd_code_in < 3'h2;
      left <= steps_in;
      info_out <= '0;
    end
  end
endmodule : ssr_motion_model

// [testbench/ssr_status_tb_top.sv]
// Self-checking bench for the stepper status report block
`timescale 1ns/1ns
module ssr_status_tb_top;
  import ssr_pkg::*;
  localparam int unsigned HD = 10;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic busy, done, cmd_v, cmd_dir, hold, irq;
  ssr_done_t info;
  // Order: base, power, cw outer, ccw outer, cw inner, ccw inner
  logic [5:0] sw = 6'h3f;
  logic [4:0] phase = '0;
  logic [1:0] stop = '0;
  logic ce = 1'h1;
  logic [2:0] cmd_code;
  logic [STEP_W-1:0] steps;
  int errors = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  ssr_status #(.HOLD_DELAY_CYCLES(HD)) uut (
    .SYS_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .CE_IN(ce),
    .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready),
    .MOTION_BUSY_IN(busy),
    .MOTION_DONE_IN(done),
    .MOTION_DONE_INFO_IN(info),
    .CCW_INNER_LIMIT_IN(sw[0]),
    .CW_INNER_LIMIT_IN(sw[1]),
    .CCW_OUTER_LIMIT_IN(sw[2]),
    .CW_OUTER_LIMIT_IN(sw[3]),
    .MOTOR_POWER_SENSE_IN(sw[4]),
    .BASE_POINT_INPUT_IN(sw[5]),
    .PHASE_DRIVE_OUTPUTS_IN(phase),
    .CMD_VALID_OUT(cmd_v),
    .CMD_CODE_OUT(cmd_code),
    .CMD_DIR_OUT(cmd_dir),
    .STEP_COUNT_VALUE_OUT(steps),
    .HOLD_OUTPUT_OUT(hold),
    .IRQ_OUT(irq)
  );

  ssr_motion_model mdl (
    .clk_in(clk),
    .rst_n_in(rst_n),
    .cmd_valid_in(cmd_v),
    .cmd_code_in(cmd_code),
    .steps_in(steps),
    .stop_in(stop),
    .busy_out(busy),
    .done_out(done),
    .info_out(info)
  );

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    // Lets the lowered ready land before the next transfer
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  task automatic idle();
    int n = 0;
    repeat (2) @(posedge clk);
    while (busy && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : idle

  task automatic t_regs();
    rd(8'h40);
    chk("unmapped", {r, d[29:0]}, {RESP_DECERR, 30'h0});
    wr(OFS_INPUT, 32'hff);
    chk("ro write", r, RESP_OKAY);
    rd(OFS_FINISH);
    chk("finish rst", d, 32'h0);
  endtask : t_regs

  task automatic t_inputs();
    for (int i = 0; i < 6; i++)
    begin
      sw <= 6'h3f ^ (6'h1 << i);
      repeat (3) @(posedge clk);
      rd(OFS_INPUT);
      chk("input", d & 32'hcf, {24'h0, sw[5:4], 2'h0, sw[3:0]});
      if (i == 4)
      begin
        rd(OFS_FINISH);
        chk("power bit", d, 32'h20);
        wr(OFS_COMMAND, 32'h2);
        chk("no power", r, RESP_SLVERR);
      end
    end
    sw <= 6'h3f;
    repeat (3) @(posedge clk);
    rd(OFS_INPUT);
    chk("input live", d & 32'hcf, 32'hcf);
  endtask : t_inputs

  // Input status must keep its frozen value while the enable is low
  task automatic t_freeze();
    ce <= 1'h0;
    @(posedge clk);
    sw <= 6'h3e;
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    rd(OFS_INPUT);
    chk("ce freeze", d & 32'hcf, 32'hcf);
    rd(OFS_INPUT);
    chk("ce resume", d & 32'hcf, 32'hce);
    sw <= 6'h3f;
    repeat (3) @(posedge clk);
  endtask : t_freeze

  task automatic t_runs();
    logic [7:0] f;
    wr(OFS_CONTROL, 32'h3);
    wr(OFS_STEPS, 32'h3);
    chk("steps", steps, 32'h3);
    for (int c = 2; c < 8; c++)
    begin
      phase <= {c[2:0], 2'h1};
      stop <= (c == 5) ? 2'h2 : (c == 6) ? 2'h1 : 2'h0;
      wr(OFS_COMMAND, {28'h0, c[0], c[2:0]});
      chk("cmd", {cmd_dir, cmd_code}, {c[0], c[2:0]});
      idle();
      f = {1'h1, 2'h0, stop[1], stop[0], c[2:0]};
      stop <= 2'h0;
      chk("hold low", hold, 1'h0);
      chk("irq set", irq, 1'h1);
      rd(OFS_FINISH);
      chk("finish", d, f);
      rd(OFS_INPUT);
      rd(OFS_OUTPUT);
      chk("output", d & 32'hfa, {c[2:0], 2'h1, 1'h0, c[0], 1'h0});
      rd(OFS_REMAIN);
      chk("remain", d, (f[4:3] != 2'h0) ? 32'h3 : 32'h0);
      rd(OFS_FINISH);
      chk("finish 2nd", d, f);
      rd(OFS_FINISH);
      chk("flag clear", d, {25'h0, f[6:0]});
      chk("irq clear", irq, 1'h0);
      repeat (HD + 2) @(posedge clk);
      chk("hold high", hold, 1'h1);
    end
  endtask : t_runs

  task automatic t_abort();
    wr(OFS_STEPS, 32'hc8);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_COMMAND, 32'h4);
      repeat (4) @(posedge clk);
      rd(OFS_FINISH);
      chk("busy read", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
      wr(OFS_COMMAND, 32'h2);
      chk("busy cmd", r, RESP_SLVERR);
      rd(OFS_STATUS);
      chk("status", d[1:0], 2'h3);
      wr(OFS_COMMAND, 32'(k));
      chk("stop ok", r, RESP_OKAY);
      idle();
      rd(OFS_FINISH);
      chk("aborted", d, 32'hc0 | 32'(k));
      rd(OFS_REMAIN);
      chk("left", (d > 32'h0 && d < 32'hc8), 1'h1);
      rd(OFS_FINISH);
    end
  endtask : t_abort

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_inputs();
    t_freeze();
    t_runs();
    t_abort();
    end_of_test();
  end

  // Tests need well under a thousand cycles, so this leaves a wide margin
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : ssr_status_tb_top
